// ### src/motor_autotune_sequencer.v
// stator-resistance auto-tuning sequencer with AHB-Lite register slave
// Contract
// - cold setting off means no cold measurement
// - cold armed forces request to power-up
// - armed cold measures on next start
// - completed cold measurement stores milliohm value
// - request off means no tuning
// - immediate tunes soon, then done or off
// - fault indication only when handling is yes
// - done keeps last results, no retune
// - each-start mode tunes on every start
// - power-up mode tunes after every power-up
// - logic-input mode tunes on rising edge
// - rated setting change after a successful tuning returns request off
// - tuning starts only with no command active
// - tuning lasts at most two seconds
// - read-only state, resets to not-tuned
// - state awaiting while requested, not started
// - state measuring during whole tuning
// - state failed after unsuccessful tuning
// - state done when measured value used
// - state entered when cold value used
`include "autotune_consts.vh"

module motor_autotune_sequencer (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire start_command,
  input wire other_command,
  input wire [15:0] logic_input_n,
  input wire stop_inputs_ok,
  input wire measure_done,
  input wire measure_ok,
  input wire [15:0] measured_res,
  output reg measure_start,
  output reg measure_busy,
  output reg tuning_fault_indication,
  output reg [15:0] resistance_in_use,
  output reg [2:0] tuning_state
);

  parameter [31:0] TUNE_TIMEOUT = (`TUNE_MAX_MS * `CLK_KHZ);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg [2:0] tuning_request_r;
  reg [15:0] cold_winding_resistance_r;
  reg tuning_fault_handling_r;
  reg [`LI_SEL_W-1:0] li_sel_r;
  reg [`RATED_W-1:0] rated_r;
  reg pending_r;
  reg power_up_r;
  reg cold_run_r;
  reg busy_r;
  reg [31:0] timer_r;
  reg start_prev_r;
  reg tuned_ok_r;
  reg wr_awaiting_measurement_r;
  reg [`ADDR_W-1:0] addr_r;
  reg [31:0] rdata_r;
  reg [31:0] read_word;
  reg trigger_hit;
  reg trigger_keep;

  wire [`LI_COUNT-1:0] li_rise_vec;
  wire li_rise = li_rise_vec[li_sel_r];
  wire start_rise = start_command & ~start_prev_r;
  wire cold_armed = (cold_winding_resistance_r == `COLD_ARM);
  wire cold_entered = (cold_winding_resistance_r != `COLD_OFF) & ~cold_armed;
  wire idle_cmd = ~start_command & ~other_command & stop_inputs_ok;
  wire timeout = (timer_r >= TUNE_TIMEOUT - `TIMER_STEP);
  wire finish = busy_r & (measure_done | timeout);
  wire ok = measure_done & measure_ok;
  wire launch = pending_r & ~busy_r & idle_cmd;
  wire addr_ok = hsel & hready & htrans[`HTRANS_NONSEQ_BIT];
  wire wr_req = wr_awaiting_measurement_r;
  wire wr_request = wr_req & (addr_r == `OFS_TUNING_REQUEST);
  wire wr_cold = wr_req & (addr_r == `OFS_COLD_RES);
  wire wr_config = wr_req & (addr_r == `OFS_FAULT_HANDLING);
  wire wr_rated = wr_req & (addr_r == `OFS_RATED);

  // ****************************************************************
  // logic input edges
  // ****************************************************************
  // each input keeps its own history, so a new selection cannot fake an edge
  genvar gi;
  generate
    for (gi = 0; gi < `LI_COUNT; gi = gi + 1) begin : g_li_edge
      reg prev_r;
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          prev_r <= 1'b0;
        end else begin
          prev_r <= logic_input_n[gi];
        end
      end
      assign li_rise_vec[gi] = logic_input_n[gi] & ~prev_r;
    end
  endgenerate

  // ****************************************************************
  // bus: zero-wait slave, unmapped reads zero, writes ignored
  // ****************************************************************
  assign hreadyout = 1'b1;
  assign hresp = `OKAY;
  assign hrdata = rdata_r;

  always @* begin
    read_word = 32'h00000000;
    case (haddr[`ADDR_W-1:0])
      `OFS_TUNING_REQUEST: read_word = {29'h0, tuning_request_r};
      `OFS_COLD_RES: read_word = {16'h0, cold_winding_resistance_r};
      `OFS_FAULT_HANDLING: read_word = {27'h0, li_sel_r, tuning_fault_handling_r};
      `OFS_TUNING_STATE: read_word = {29'h0, tuning_state};
      `OFS_RATED: read_word = rated_r;
      `OFS_STATUS: read_word = {29'h0, tuning_fault_indication, busy_r, pending_r};
      default: read_word = 32'h00000000;
    endcase
  end

  // read data stands for the data phase only and is zero elsewhere
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_awaiting_measurement_r <= 1'b0;
      addr_r <= 8'h00;
      rdata_r <= 32'h00000000;
    end else begin
      wr_awaiting_measurement_r <= addr_ok & hwrite;
      addr_r <= haddr[`ADDR_W-1:0];
      if (addr_ok & ~hwrite) begin
        rdata_r <= read_word;
      end else begin
        rdata_r <= 32'h00000000;
      end
    end
  end

  // ****************************************************************
  // configuration written only by software
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tuning_fault_handling_r <= 1'b0;
      li_sel_r <= {`LI_SEL_W{1'b0}};
      rated_r <= {`RATED_W{1'b0}};
    end else if (wr_config) begin
      tuning_fault_handling_r <= hwdata[`HANDLING_BIT];
      li_sel_r <= hwdata[`LI_SEL_MSB:`LI_SEL_LSB];
    end else if (wr_rated) begin
      rated_r <= hwdata;
    end
  end

  // ****************************************************************
  // tuning timer
  // ****************************************************************
  // a stalled measurement must not hold the drive, so the timer ends it as a failure
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_r <= 32'h00000000;
    end else if (launch) begin
      timer_r <= 32'h00000000;
    end else if (busy_r) begin
      timer_r <= timer_r + `TIMER_STEP;
    end
  end

  // ****************************************************************
  // command edge and start pulse
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_prev_r <= 1'b0;
      measure_start <= 1'b0;
    end else begin
      start_prev_r <= start_command;
      measure_start <= launch;
    end
  end

  // ****************************************************************
  // power-up and cold run latches
  // ****************************************************************
  // a power-up request survives until the first tuning really launches
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_up_r <= 1'b1;
      cold_run_r <= 1'b0;
    end else if (launch) begin
      power_up_r <= 1'b0;
      cold_run_r <= cold_armed;
    end
  end

  // ****************************************************************
  // busy
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy_r <= 1'b0;
      measure_busy <= 1'b0;
    end else if (launch) begin
      busy_r <= 1'b1;
      measure_busy <= 1'b1;
    end else if (finish) begin
      busy_r <= 1'b0;
      measure_busy <= 1'b0;
    end
  end

  // ****************************************************************
  // fault indication
  // ****************************************************************
  // a failure in the cycle of a request write wins, so no fault is lost
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tuning_fault_indication <= 1'b0;
    end else if (finish & ~ok & tuning_fault_handling_r) begin
      tuning_fault_indication <= 1'b1;
    end else if (wr_request) begin
      tuning_fault_indication <= 1'b0;
    end
  end

  // ****************************************************************
  // trigger decode
  // ****************************************************************
  // off and done drop any waiting request; the other modes only add to it
  always @* begin
    trigger_hit = 1'b0;
    trigger_keep = 1'b1;
    case (tuning_request_r)
      `TREQ_IMMEDIATE: begin
        trigger_hit = 1'b1;
      end
      `TREQ_EACH_START: begin
        trigger_hit = start_rise;
      end
      `TREQ_POWER_UP: begin
        trigger_hit = power_up_r | (cold_armed & start_rise);
      end
      `TREQ_LOGIC_INPUT: begin
        trigger_hit = li_rise;
      end
      default: begin
        trigger_keep = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // pending request
  // ****************************************************************
  // triggers during a run are ignored rather than queued behind it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_r <= 1'b0;
    end else if (launch) begin
      pending_r <= 1'b0;
    end else if (!busy_r) begin
      pending_r <= trigger_hit | (pending_r & trigger_keep);
    end
  end

  // ****************************************************************
  // sequencer
  // ****************************************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tuning_request_r <= `TREQ_OFF;
      cold_winding_resistance_r <= `COLD_OFF;
      tuned_ok_r <= 1'b0;
      resistance_in_use <= 16'h0000;
      tuning_state <= `TST_NOT_TUNED;
    end else begin
      // software writes
      if (wr_request) begin
        tuning_request_r <= hwdata[`REQ_W-1:0];
      end
      if (wr_cold) begin
        cold_winding_resistance_r <= hwdata[`RES_W-1:0];
      end
      if (wr_rated && hwdata != rated_r && tuned_ok_r) begin
        tuning_request_r <= `TREQ_OFF;
        tuned_ok_r <= 1'b0;
      end

      // an armed cold setting overrides whatever software wrote
      if (cold_armed) begin
        tuning_request_r <= `TREQ_POWER_UP;
      end

      if (!busy_r && pending_r) begin
        tuning_state <= `TST_AWAITING;
      end
      if (launch) begin
        tuning_state <= `TST_MEASURING;
      end

      if (finish) begin
        if (ok) begin
          tuned_ok_r <= 1'b1;
          resistance_in_use <= measured_res;
          if (cold_run_r) begin
            cold_winding_resistance_r <= measured_res;
            tuning_state <= `TST_ENTERED;
          end else begin
            tuning_state <= `TST_DONE;
          end
          if (tuning_request_r == `TREQ_IMMEDIATE) begin
            tuning_request_r <= `TREQ_DONE;
          end
        end else begin
          tuning_state <= `TST_FAILED;
          if (tuning_request_r == `TREQ_IMMEDIATE) begin
            tuning_request_r <= `TREQ_OFF;
          end
        end
      end else if (!busy_r && !pending_r && cold_entered
                   && (tuning_state != `TST_ENTERED
                       || resistance_in_use != cold_winding_resistance_r)) begin
        // an entered cold value overrides the measured one, also when re-entered
        resistance_in_use <= cold_winding_resistance_r;
        tuning_state <= `TST_ENTERED;
      end
    end
  end

endmodule // motor_autotune_sequencer

// ### src/autotune_consts.vh
// constants for the auto-tuning sequencer
`ifndef AUTOTUNE_CONSTS_VH
`define AUTOTUNE_CONSTS_VH

// ****************************************************************
// bus register map (byte addresses)
// ****************************************************************
`define OFS_TUNING_REQUEST 8'h00
`define OFS_COLD_RES 8'h04
`define OFS_FAULT_HANDLING 8'h08
`define OFS_TUNING_STATE 8'h0C
`define OFS_RATED 8'h10
`define OFS_STATUS 8'h14

// ****************************************************************
// tuning_request encodings
// ****************************************************************
`define TREQ_OFF 3'h0
`define TREQ_IMMEDIATE 3'h1
`define TREQ_DONE 3'h2
`define TREQ_EACH_START 3'h3
`define TREQ_POWER_UP 3'h4
`define TREQ_LOGIC_INPUT 3'h5

// ****************************************************************
// tuning_state encodings
// ****************************************************************
`define TST_NOT_TUNED 3'h0
`define TST_AWAITING 3'h1
`define TST_MEASURING 3'h2
`define TST_FAILED 3'h3
`define TST_DONE 3'h4
`define TST_ENTERED 3'h5

// ****************************************************************
// cold_winding_resistance special values, 16-bit milliohms
// ****************************************************************
`define COLD_OFF 16'h0000
`define COLD_ARM 16'hFFFF

// ****************************************************************
// widths, bit positions, timing
// ****************************************************************
`define LI_SEL_W 4
`define LI_SEL_LSB 1
`define LI_SEL_MSB 4
`define LI_COUNT 16
`define HANDLING_BIT 0
`define ADDR_W 8
`define REQ_W 3
`define RES_W 16
`define TIMER_STEP 32'h1
`define RATED_W 32
`define TUNE_MAX_MS 2000
`define CLK_KHZ 20000
`define OKAY 1'b0
`define HTRANS_NONSEQ_BIT 1

`endif

// ### verification/autotune_asserts.sv
// port checker for the tuning sequencer
`include "autotune_consts.vh"
module autotune_asserts #(parameter [31:0] TUNE_TIMEOUT = 50) (
  input wire hclk,
  input wire hresetn,
  input wire hreadyout,
  input wire hresp,
  input wire start_command,
  input wire other_command,
  input wire stop_inputs_ok,
  input wire measure_done,
  input wire measure_start,
  input wire measure_busy,
  input wire tuning_fault_indication,
  input wire [2:0] tuning_state
);
  timeunit 1ns;
  timeprecision 1ns;
  // margin covers the launch and end registers around the timeout
  localparam int BUSY_MAX = TUNE_TIMEOUT + 4;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_launch;
    $rose(measure_start);
  endsequence
  sequence s_finish;
    $fell(measure_busy);
  endsequence
  AST_BUS_OKAY: assert property (hreadyout && hresp == `OKAY)
    else $error("bus answer not okay");
  AST_START_PULSE: assert property (measure_start |=> !measure_start)
    else $error("start pulse too long");
  AST_LAUNCH_IDLE: assert property (
    s_launch |-> $past(!start_command && !other_command && stop_inputs_ok))
    else $error("launch while a command was active");
  AST_MEAS_STATE: assert property (
    measure_busy |-> tuning_state == `TST_MEASURING) else $error("busy not measuring");
  AST_BUSY_BOUND: assert property (
    $rose(measure_busy) |-> ##[1:BUSY_MAX] !measure_busy) else $error("tuning too long");
  AST_DONE_ENDS: assert property (
    measure_busy && measure_done |-> ##[1:2] !measure_busy) else $error("no end on done");
  AST_RESULT: assert property (s_finish |-> tuning_state inside
    {`TST_FAILED, `TST_DONE, `TST_ENTERED}) else $error("no result state");
  AST_FAULT_CAUSE: assert property (
    $rose(tuning_fault_indication) |-> tuning_state == `TST_FAILED) else $error("stray fault");
  AST_STATE_CODE: assert property (tuning_state <= `TST_ENTERED)
    else $error("bad state code");
endmodule // autotune_asserts

// ### verification/measure_model.sv
// measurement responder on the far side of the sequencer
module measure_model (
  input wire hclk,
  input wire hresetn,
  input wire measure_start,
  input wire m_ok,
  input wire [15:0] res,
  input int m_dly,
  output logic measure_done,
  output logic measure_ok,
  output logic [15:0] measured_res
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // result lines toggle outside the done pulse so stale values never look valid
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      measure_done <= 1'b0;
      measure_ok <= 1'b0;
      measured_res <= 16'h0000;
    end else begin
      measure_done <= 1'b0;
      measure_ok <= ~measure_ok;
      measured_res <= ~measured_res;
      if (measure_start) cnt <= m_dly;
      else if (cnt > 1) cnt <= cnt - 1;
      else if (cnt == 1) begin
        cnt <= 0;
        measure_done <= 1'b1;
        measure_ok <= m_ok;
        measured_res <= res;
      end
    end
  end
endmodule // measure_model

// ### verification/tb_top.sv
// self-checking bench for the tuning sequencer
`include "autotune_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, start_command = 0, other_command = 0;
  logic stop_inputs_ok = 1, m_ok = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, q;
  logic [15:0] logic_input_n = 0, res = 16'h1234;
  int m_dly = 5, fails = 0, cmp_count = 0, n_tunes = 0, k, nt;
  wire [31:0] hrdata;
  wire hreadyout, hresp, measure_done, measure_ok, measure_start, measure_busy;
  wire tuning_fault_indication;
  wire [15:0] measured_res, resistance_in_use;
  wire [2:0] tuning_state;
  always #25 hclk = ~hclk;
  always @(posedge hclk) if (measure_start === 1'b1) n_tunes++;
  motor_autotune_sequencer #(.TUNE_TIMEOUT(50)) i_motor_autotune_sequencer (
    .hready(hreadyout), .hsize(3'h2), .*);
  measure_model i_measure_model (.*);
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask
  task pulse;
    start_command <= 1'b1;
    repeat (3) @(posedge hclk);
    start_command <= 1'b0;
  endtask
  // launch takes a few cycles, so busy is only polled after that
  task settle;
    k = 0;
    repeat (4) @(posedge hclk);
    while (measure_busy !== 1'b0 && k < 400) begin
      @(posedge hclk);
      k++;
    end
    repeat (3) @(posedge hclk);
  endtask
  task finish_test;
    if (fails == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #(50 * 40000);
    fails++;
    finish_test;
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    k = $urandom(32'h480b0b7f);
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`OFS_TUNING_STATE, `TST_NOT_TUNED);
    bus(1'b1, `OFS_TUNING_STATE, 32'h5);
    rd(`OFS_TUNING_STATE, `TST_NOT_TUNED);
    rd(8'h20, 32'h0);
    pulse;
    settle;
    chk("tunes", 0, n_tunes);
    for (int i = 0; i < 4; i++) begin
      m_ok <= (i == 0 || i == 3);
      res <= $urandom_range(16'hFFFE, 1);
      bus(1'b1, `OFS_FAULT_HANDLING, {31'h0, i[1]});
      bus(1'b1, `OFS_TUNING_REQUEST, `TREQ_IMMEDIATE);
      settle;
      rd(`OFS_TUNING_REQUEST, m_ok ? `TREQ_DONE : `TREQ_OFF);
      rd(`OFS_TUNING_STATE, m_ok ? `TST_DONE : `TST_FAILED);
      chk("fault", !m_ok && i[1], tuning_fault_indication);
      if (m_ok) chk("res", res, resistance_in_use);
    end
    nt = n_tunes;
    pulse;
    settle;
    chk("tunes", nt, n_tunes);
    bus(1'b1, `OFS_RATED, $urandom | 32'h1);
    rd(`OFS_TUNING_REQUEST, `TREQ_OFF);
    {other_command, stop_inputs_ok} <= 2'b10;
    bus(1'b1, `OFS_TUNING_REQUEST, `TREQ_IMMEDIATE);
    repeat (3) @(posedge hclk);
    rd(`OFS_TUNING_STATE, `TST_AWAITING);
    other_command <= 1'b0;
    repeat (10) @(posedge hclk);
    chk("tunes", nt, n_tunes);
    stop_inputs_ok <= 1'b1;
    m_dly <= 200;
    settle;
    rd(`OFS_TUNING_STATE, `TST_FAILED);
    m_dly <= 5;
    bus(1'b1, `OFS_TUNING_REQUEST, `TREQ_EACH_START);
    nt = n_tunes;
    repeat (2) begin
      pulse;
      settle;
    end
    chk("tunes", nt + 2, n_tunes);
    k = $urandom_range(15, 0);
    bus(1'b1, `OFS_FAULT_HANDLING, k << 1);
    bus(1'b1, `OFS_TUNING_REQUEST, `TREQ_LOGIC_INPUT);
    logic_input_n[k] <= 1'b1;
    settle;
    repeat (20) @(posedge hclk);
    chk("tunes", nt + 3, n_tunes);
    bus(1'b1, `OFS_COLD_RES, {16'h0, `COLD_ARM});
    rd(`OFS_TUNING_REQUEST, `TREQ_POWER_UP);
    rd(`OFS_COLD_RES, {16'h0, `COLD_ARM});
    pulse;
    settle;
    rd(`OFS_COLD_RES, {16'h0, res});
    rd(`OFS_TUNING_STATE, `TST_ENTERED);
    res <= $urandom_range(16'hFFFE, 1);
    @(posedge hclk);
    bus(1'b1, `OFS_COLD_RES, {16'h0, res});
    repeat (3) @(posedge hclk);
    chk("res", res, resistance_in_use);
    rd(`OFS_TUNING_STATE, `TST_ENTERED);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    nt = n_tunes;
    bus(1'b1, `OFS_TUNING_REQUEST, `TREQ_POWER_UP);
    settle;
    chk("tunes", nt + 1, n_tunes);
    rd(`OFS_TUNING_STATE, `TST_DONE);
    finish_test;
  end
endmodule // tb_top
bind motor_autotune_sequencer autotune_asserts #(.TUNE_TIMEOUT(TUNE_TIMEOUT)) i_autotune_asserts (.*);
